// ===== design/fpa_pkg.sv
// Package for the fixed priority / round-robin memory-mapped arbiter.
// Assumes one clock and one reset shared with the surrounding interconnect.
package fpa_pkg;

  // ****************************************
  // Arbitration scheme (arbitration_scheme_setting)
  // ****************************************
  localparam logic SCHEME_RR = 1'h0;
  localparam logic SCHEME_FIXED = 1'h1;

  // ****************************************
  // Defaults
  // ****************************************
  localparam int NUM_MASTERS_DEF = 4;
  localparam int CMD_WIDTH_DEF = 32;
  localparam int DATA_WIDTH_DEF = 32;
  localparam int PRIO_WIDTH_DEF = 4;
  localparam int SHARE_WIDTH_DEF = 4;
  localparam int PIPE_LIMIT_DEF = 0;

  // ****************************************
  // Command path state
  // ****************************************
  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_hold = 2'h2
  } fpa_state_type;

endpackage : fpa_pkg

// ===== design/fpa_arbiter.sv
// Per-slave arbiter with command, write-data and read-data multiplexing.
// Assumes masters hold req until accept pulses and the slave returns the channel
// number with each read response.
`timescale 1ns/10ps

// Behaviour
// - Fixed scheme grants the requesting master with the highest numeric priority.
// - AXI master on fixed non-AXI slave passes an intermediary multiplexer first.
// - AXI read and write channels arbitrate as two separate requesters.
// - Intermediary alternates between simultaneous read and write of one master.
// - Toward an AXI slave the channels feed the priority muxes directly.
// - Arbiter takes all requesters and outputs the selected channel number.
// - The channel number steers the command multiplexer toward the slave.
// - One arbiter per slave, selecting among requesters in every cycle with no command held.
// - Nonzero pipeline limit registers the arbiter decision one more stage.
// - One design serves round-robin and fixed priority, chosen per slave.
// - Write data of the granted master is routed to the slave.
// - Read data from the slave returns to the requesting master.
// - One read-data multiplexer per master, one write-data multiplexer per slave.
// - No multiplexer logic where only one source drives a path.
// - Round-robin shares give a master that many transfers before moving on.
// - A master that stops requesting forfeits remaining shares once another master is granted.
// - Only requesting masters take part in arbitration.
module fpa_arbiter #(
  parameter int NUM_MASTERS = fpa_pkg::NUM_MASTERS_DEF,
  parameter int CMD_WIDTH = fpa_pkg::CMD_WIDTH_DEF,
  parameter int DATA_WIDTH = fpa_pkg::DATA_WIDTH_DEF,
  parameter int PRIO_WIDTH = fpa_pkg::PRIO_WIDTH_DEF,
  parameter int SHARE_WIDTH = fpa_pkg::SHARE_WIDTH_DEF,
  parameter int PIPE_LIMIT = fpa_pkg::PIPE_LIMIT_DEF,
  parameter logic ARBITRATION_SCHEME_SETTING = fpa_pkg::SCHEME_RR,
  parameter logic SLAVE_IS_AXI = 1'h0,
  parameter logic [NUM_MASTERS-1:0] AXI_PAIR = '0,
  parameter logic [NUM_MASTERS*PRIO_WIDTH-1:0] PRIORITY = {4'h3, 4'h2, 4'h1, 4'h0},
  parameter logic [NUM_MASTERS*SHARE_WIDTH-1:0] SHARES = {4'h1, 4'h1, 4'h1, 4'h1},
  localparam int IW = (NUM_MASTERS > 1) ? $clog2(NUM_MASTERS) : 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Master side
  input wire logic [NUM_MASTERS-1:0] req_i,
  input wire logic [NUM_MASTERS*CMD_WIDTH-1:0] cmd_i,
  input wire logic [NUM_MASTERS*DATA_WIDTH-1:0] wdata_i,
  output logic [NUM_MASTERS-1:0] accept_o,
  output logic [NUM_MASTERS-1:0] rvalid_o,
  output logic [NUM_MASTERS*DATA_WIDTH-1:0] rdata_o,
  // Slave side
  output logic cmd_valid_o,
  output logic [CMD_WIDTH-1:0] cmd_o,
  output logic [DATA_WIDTH-1:0] wdata_o,
  output logic [IW-1:0] chan_o,
  input wire logic slave_ready_i,
  input wire logic rsp_valid_i,
  input wire logic [IW-1:0] rsp_chan_i,
  input wire logic [DATA_WIDTH-1:0] rdata_i
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  localparam logic INTERMED = (ARBITRATION_SCHEME_SETTING == fpa_pkg::SCHEME_FIXED) &&
                              !SLAVE_IS_AXI;
  // Edges from the request sample that decides to the grant being visible
  localparam int DECIDE_LAG = (PIPE_LIMIT > 0) ? 2 : 1;

  if (NUM_MASTERS < 1) begin : g_chk_n
    $error("fpa_arbiter needs at least one master");
  end
  for (genvar i = 0; i < NUM_MASTERS; i++) begin : g_chk
    if (SHARES[i*SHARE_WIDTH +: SHARE_WIDTH] == '0) begin : g_share
      $error("fpa_arbiter share count of zero");
    end
    if (AXI_PAIR[i] && ((i % 2) != 0 || i + 1 >= NUM_MASTERS)) begin : g_pair
      $error("fpa_arbiter pair flag only on even channel with a partner");
    end
    for (genvar j = i + 1; j < NUM_MASTERS; j++) begin : g_dup
      if (ARBITRATION_SCHEME_SETTING == fpa_pkg::SCHEME_FIXED &&
          PRIORITY[i*PRIO_WIDTH +: PRIO_WIDTH] == PRIORITY[j*PRIO_WIDTH +: PRIO_WIDTH])
      begin : g_err
        $error("fpa_arbiter duplicate priority");
      end
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    fpa_pkg::fpa_state_type st;
    logic vld;
    logic [IW-1:0] last;
    logic [SHARE_WIDTH-1:0] left;
    logic [IW-1:0] win_q;
    logic win_ok;
    logic [NUM_MASTERS-1:0] fav;
    logic [NUM_MASTERS-1:0] accept;
    logic [IW-1:0] chan;
    logic [CMD_WIDTH-1:0] cmd;
    logic [DATA_WIDTH-1:0] wdata;
    logic [NUM_MASTERS-1:0] rvalid;
    logic [NUM_MASTERS*DATA_WIDTH-1:0] rdata;
  } fpa_regs_type;

  fpa_regs_type s;
  fpa_regs_type next_s;
  logic [NUM_MASTERS-1:0] elig;
  logic found;
  logic [IW-1:0] win;
  logic [PRIO_WIDTH-1:0] best_prio;
  logic use_ok;
  logic [IW-1:0] use_win;
  int idx;

  // ****************************************
  // Arbitration and multiplexing
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.accept = '0;
    next_s.rvalid = '0;
    // Only live requests compete; behind the intermediary a paired AXI master shows one channel at a time
    elig = req_i;
    for (int m = 0; m + 1 < NUM_MASTERS; m++) begin
      if (INTERMED && AXI_PAIR[m] && req_i[m] && req_i[m+1]) begin
        if (s.fav[m]) begin
          elig[m] = 1'b0;
        end else begin
          elig[m+1] = 1'b0;
        end
      end
    end
    found = 1'b0;
    win = '0;
    best_prio = '0;
    idx = 0;
    if (ARBITRATION_SCHEME_SETTING == fpa_pkg::SCHEME_FIXED) begin
      for (int m = 0; m < NUM_MASTERS; m++) begin
        if (elig[m] && (!found || PRIORITY[m*PRIO_WIDTH +: PRIO_WIDTH] > best_prio)) begin
          found = 1'b1;
          win = IW'(m);
          best_prio = PRIORITY[m*PRIO_WIDTH +: PRIO_WIDTH];
        end
      end
    end else if (elig[s.last] && s.left != '0) begin
      found = 1'b1;
      win = s.last;
    end else begin
      // Dropping the request falls through here; unused shares are gone once another master wins
      for (int k = 1; k <= NUM_MASTERS; k++) begin
        idx = (int'(s.last) + k) % NUM_MASTERS;
        if (!found && elig[idx]) begin
          found = 1'b1;
          win = IW'(idx);
        end
      end
    end
    // Registered decision trades one cycle of latency for a shorter grant path
    next_s.win_q = win;
    next_s.win_ok = found;
    if (PIPE_LIMIT > 0) begin
      use_win = s.win_q;
      use_ok = s.win_ok && req_i[s.win_q];
    end else begin
      use_win = win;
      use_ok = found;
    end
    case (s.st)
      fpa_pkg::st_idle: begin
        if (use_ok) begin
          next_s.st = fpa_pkg::st_hold;
          next_s.vld = 1'b1;
          next_s.chan = use_win;
          next_s.cmd = cmd_i[use_win*CMD_WIDTH +: CMD_WIDTH];
          next_s.wdata = wdata_i[use_win*DATA_WIDTH +: DATA_WIDTH];
          next_s.accept[use_win] = 1'b1;
          if (use_win == s.last && s.left != '0) begin
            next_s.left = s.left - SHARE_WIDTH'(1);
          end else begin
            next_s.left = SHARES[use_win*SHARE_WIDTH +: SHARE_WIDTH] - SHARE_WIDTH'(1);
          end
          next_s.last = use_win;
          for (int m = 0; m + 1 < NUM_MASTERS; m++) begin
            if (AXI_PAIR[m] && (int'(use_win) == m || int'(use_win) == m + 1)) begin
              next_s.fav[m] = (int'(use_win) == m);
            end
          end
        end
      end
      fpa_pkg::st_hold: begin
        if (slave_ready_i) begin
          next_s.st = fpa_pkg::st_idle;
          next_s.vld = 1'b0;
        end
      end
      default: begin
        next_s.st = fpa_pkg::st_idle;
        next_s.vld = 1'b0;
      end
    endcase
    // One read-data path per master, filled only by responses tagged for it
    for (int m = 0; m < NUM_MASTERS; m++) begin
      if (rsp_valid_i && int'(rsp_chan_i) == m) begin
        next_s.rvalid[m] = 1'b1;
        next_s.rdata[m*DATA_WIDTH +: DATA_WIDTH] = rdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.st <= fpa_pkg::st_idle;
      // Rotation begins after the top channel, so channel 0 is seen first
      s.last <= IW'(NUM_MASTERS - 1);
    end else begin
      s <= next_s;
    end
  end

  assign accept_o = s.accept;
  assign rvalid_o = s.rvalid;
  assign rdata_o = s.rdata;
  assign cmd_valid_o = s.vld;
  assign cmd_o = s.cmd;
  assign wdata_o = s.wdata;
  assign chan_o = s.chan;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking fpa_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  grant_onehot_a: assert property ($onehot0(accept_o))
    else $error("more than one master accepted");
  chan_matches_a: assert property (accept_o != '0 |-> accept_o[chan_o] && cmd_valid_o)
    else $error("channel number disagrees with accepted master");
  cmd_hold_a: assert property (cmd_valid_o && !slave_ready_i |=> cmd_valid_o && $stable(cmd_o))
    else $error("command dropped before slave took it");
  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_asrt
    cmd_route_a: assert property (accept_o[m] |->
      cmd_o == $past(cmd_i[m*CMD_WIDTH +: CMD_WIDTH]) &&
      wdata_o == $past(wdata_i[m*DATA_WIDTH +: DATA_WIDTH]))
      else $error("granted master data not routed to slave");
    only_req_a: assert property (accept_o[m] |-> $past(req_i[m]))
      else $error("grant to master that did not request");
    rdata_route_a: assert property ($past(rsp_valid_i) && $past(rsp_chan_i) == m |->
      rvalid_o[m] && rdata_o[m*DATA_WIDTH +: DATA_WIDTH] == $past(rdata_i))
      else $error("read data not returned to its master");
    for (genvar j = 0; j < NUM_MASTERS; j++) begin : g_prio
      // The intermediary may hide a paired channel, so those are left out
      if (ARBITRATION_SCHEME_SETTING == fpa_pkg::SCHEME_FIXED &&
          !(INTERMED && (AXI_PAIR[j] || (j > 0 && AXI_PAIR[(j > 0) ? j - 1 : 0]))) &&
          PRIORITY[j*PRIO_WIDTH +: PRIO_WIDTH] > PRIORITY[m*PRIO_WIDTH +: PRIO_WIDTH])
      begin : g_hi
        fixed_prio_a: assert property (accept_o[m] |-> !$past(req_i[j], DECIDE_LAG))
          else $error("lower priority master won over a higher one");
      end
    end
  end

endmodule : fpa_arbiter

// ===== verification/fpa_slave_model.sv
// Slave-side partner for the arbiter bench: random ready, one read reply per taken command.
// Assumes the bench seeds $urandom and that the arbiter has four masters (two-bit channel).
`timescale 1ns/10ps
module fpa_slave_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Command from the arbiter
  input wire logic cmd_valid_i,
  input wire logic [1:0] chan_i,
  // Replies to the arbiter
  output logic slave_ready_o,
  output logic rsp_valid_o,
  output logic [1:0] rsp_chan_o,
  output logic [31:0] rdata_o
);
  logic took;
  logic [1:0] took_chan;

  initial begin
    slave_ready_o = 1'h0;
    rsp_valid_o = 1'h0;
    rsp_chan_o = 2'h0;
    rdata_o = 32'h0;
    took = 1'h0;
    took_chan = 2'h0;
  end

  always @(posedge core_clk_i) begin
    took = resetn_i && cmd_valid_i && slave_ready_o;
    took_chan = chan_i;
  end

  // Idle reply lines flip every cycle so a stale value never passes for a reply
  always @(negedge core_clk_i) begin
    slave_ready_o = ($urandom % 4) != 0;
    rsp_valid_o = took;
    rsp_chan_o = took ? took_chan : ~rsp_chan_o;
    rdata_o = took ? $urandom : ~rdata_o;
  end
endmodule : fpa_slave_model

// ===== verification/fixed_priority_mm_arbiter_tb.sv
// Self-checking bench: a round-robin arbiter with weighted shares, and a fixed-priority one
// with an intermediary pair and a registered decision, fed by the same masters.
// Assumes four masters of 32-bit command and data; reference models predict each grant.
`timescale 1ns/10ps
module fixed_priority_mm_arbiter_tb;
  localparam logic [15:0] SHR = {4'h2, 4'h1, 4'h3, 4'h1};
  logic core_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic [3:0] req = 4'h0;
  logic [127:0] cmd = '0;
  logic [127:0] wd = '0;
  logic [3:0] accept_o, rvalid_o;
  logic [127:0] rdata_o;
  logic cmd_valid_o, slave_ready_i, rsp_valid_i;
  logic [31:0] cmd_o, wdata_o, rdata_i, ecmd, ewd, rd;
  logic [1:0] chan_o, rsp_chan_i;
  logic go = 1'h0;
  logic first = 1'h1;
  logic pend = 1'h0;
  logic rpend = 1'h0;
  int left[4] = '{30, 30, 30, 30};
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int ptr, cnt, w, rk;
  localparam logic [15:0] FPRI = {4'h1, 4'h3, 4'h0, 4'h2};
  logic [3:0] f_accept, f_rvalid;
  logic [127:0] f_rdata;
  logic f_valid;
  logic [31:0] f_cmd, f_wdata, fcmd, fwd;
  logic [1:0] f_chan;
  logic busy = 1'h0;
  logic fbusy = 1'h0;
  logic fpend = 1'h0;
  logic fav = 1'h0;
  logic fok = 1'h0;
  int fq, fw, fn;

  fpa_arbiter #(.SHARES(SHR)) i_dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_i(req), .cmd_i(cmd), .wdata_i(wd),
    .accept_o(accept_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o), .cmd_valid_o(cmd_valid_o),
    .cmd_o(cmd_o), .wdata_o(wdata_o), .chan_o(chan_o), .slave_ready_i(slave_ready_i),
    .rsp_valid_i(rsp_valid_i), .rsp_chan_i(rsp_chan_i), .rdata_i(rdata_i));

  fpa_slave_model i_slave (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_o), .chan_i(chan_o),
    .slave_ready_o(slave_ready_i), .rsp_valid_o(rsp_valid_i), .rsp_chan_o(rsp_chan_i),
    .rdata_o(rdata_i));

  // Fixed-priority slave: channels 0/1 are one read/write master behind an intermediary
  if (1) begin : g_fix
    fpa_arbiter #(.PIPE_LIMIT(1), .ARBITRATION_SCHEME_SETTING(fpa_pkg::SCHEME_FIXED),
      .AXI_PAIR(4'h1), .PRIORITY(FPRI)) i_dut (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_i(req), .cmd_i(cmd), .wdata_i(wd),
      .accept_o(f_accept), .rvalid_o(f_rvalid), .rdata_o(f_rdata), .cmd_valid_o(f_valid),
      .cmd_o(f_cmd), .wdata_o(f_wdata), .chan_o(f_chan), .slave_ready_i(slave_ready_i),
      .rsp_valid_i(rsp_valid_i), .rsp_chan_i(rsp_chan_i), .rdata_i(rdata_i));
  end

  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  // ****************************************
  // Checking
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  function automatic int next_win(input logic [3:0] r, input int p);
    for (int k = 1; k <= 4; k++) if (r[(p + k) % 4]) return (p + k) % 4;
    return p;
  endfunction : next_win

  // Highest numeric priority wins; of the pair, the channel not granted last
  function automatic int fix_win(input logic [3:0] r, input logic fv);
    int b;
    b = -1;
    if (r[0] && r[1]) r[fv ? 0 : 1] = 1'h0;
    for (int m = 0; m < 4; m++) if (r[m] && (b < 0 || FPRI[m*4 +: 4] > FPRI[b*4 +: 4])) b = m;
    return b;
  endfunction : fix_win

  // Reference models: grant sampled at a take edge shows one cycle later
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ptr = 3;
      cnt = 0;
      pend = 1'h0;
      rpend = 1'h0;
      busy = 1'h0;
      fbusy = 1'h0;
      fpend = 1'h0;
      fav = 1'h0;
      fok = 1'h0;
      fq = 0;
    end else begin
      if (pend) begin
        check(32'(accept_o), 32'h1 << w);
        check(32'(chan_o), 32'(w));
        check(cmd_o, ecmd);
        check(wdata_o, ewd);
      end else check(32'(accept_o), 32'h0);
      check(32'(cmd_valid_o), 32'(busy));
      if (fpend) begin
        check(32'(f_accept), 32'h1 << fw);
        check(32'(f_chan), 32'(fw));
        check(f_cmd, fcmd);
        check(f_wdata, fwd);
      end else check(32'(f_accept), 32'h0);
      check(32'(f_valid), 32'(fbusy));
      if (rpend) begin
        check(32'(rvalid_o), 32'h1 << rk);
        check(rdata_o[rk*32 +: 32], rd);
        check(f_rdata[rk*32 +: 32], rd);
      end else check(32'(rvalid_o), 32'h0);
      check(32'(f_rvalid), rpend ? 32'h1 << rk : 32'h0);
      pend = !busy && (req != 4'h0);
      busy = busy ? !slave_ready_i : pend;
      if (pend) begin
        if (req[ptr] && cnt > 0) cnt--;
        else begin
          ptr = next_win(req, ptr);
          cnt = 32'(SHR[ptr*4 +: 4]) - 1;
        end
        w = ptr;
        ecmd = cmd[w*32 +: 32];
        ewd = wd[w*32 +: 32];
      end
      // Fixed side takes the winner decided one edge earlier, if it still requests
      fpend = !fbusy && fok && req[fq];
      fbusy = fbusy ? !slave_ready_i : fpend;
      fn = fix_win(req, fav);
      if (fpend) begin
        fw = fq;
        fcmd = cmd[fw*32 +: 32];
        fwd = wd[fw*32 +: 32];
        if (fw < 2) fav = (fw == 0);
      end
      fok = fn >= 0;
      fq = fok ? fn : 0;
      rpend = rsp_valid_i;
      rk = 32'(rsp_chan_i);
      rd = rdata_i;
    end
  end

  // ****************************************
  // Masters and run control
  // ****************************************
  // All masters request together first, then with random gaps that forfeit shares if another master is granted
  always @(negedge core_clk_i) begin
    if (go) begin
      for (int m = 0; m < 4; m++) begin
        if (accept_o[m]) begin
          req[m] = 1'h0;
          left[m] = left[m] - 1;
        end else if (!req[m] && left[m] > 0 && (first || $urandom % 3 != 0)) begin
          req[m] = 1'h1;
          cmd[m*32 +: 32] = $urandom;
          wd[m*32 +: 32] = $urandom;
        end
      end
      first = 1'h0;
    end
  end

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    void'($urandom(34594));
    repeat (5) @(negedge core_clk_i);
    resetn_i = 1'h1;
    repeat (2) @(negedge core_clk_i);
    go <= 1'h1;
    wait (left.sum() == 0);
    repeat (6) @(negedge core_clk_i);
    final_report();
  end
endmodule : fixed_priority_mm_arbiter_tb
